/* File: rtl/rtcc_pkg.sv */
// Constants, offsets and types shared by the calendar clock design.
package rtcc_pkg;

   // ***********************************************************
   // Oscillator and divider timing.
   // ***********************************************************
   localparam int unsigned OSC_HZ = 32768;
   localparam int unsigned DIV_W = 15;
   localparam logic [14:0] DIV_TOP = 15'h7fff;
   localparam int unsigned UIP_LEAD_US = 488;
   localparam int unsigned UIP_LEAD_TICKS =
      (UIP_LEAD_US * OSC_HZ + 999999) / 1000000;
   localparam logic [14:0] UIP_START = DIV_TOP - 15'(UIP_LEAD_TICKS);
   localparam logic [2:0] DIV_NORMAL = 3'h2;

   // ***********************************************************
   // Location indices of the lower bank.
   // ***********************************************************
   localparam int unsigned IDX_SEC = 0;
   localparam int unsigned IDX_SEC_ALM = 1;
   localparam int unsigned IDX_MIN = 2;
   localparam int unsigned IDX_MIN_ALM = 3;
   localparam int unsigned IDX_HR = 4;
   localparam int unsigned IDX_HR_ALM = 5;
   localparam int unsigned IDX_DOW = 6;
   localparam int unsigned IDX_DATE = 7;
   localparam int unsigned IDX_MON = 8;
   localparam int unsigned IDX_YEAR = 9;
   localparam int unsigned TIME_LOCS = 10;
   localparam logic [7:0] IDX_REG_A = 8'h0a;
   localparam logic [7:0] IDX_REG_B = 8'h0b;
   localparam logic [7:0] IDX_REG_C = 8'h0c;
   localparam logic [7:0] IDX_REG_D = 8'h0d;
   localparam int unsigned BANK_BYTES = 128;
   localparam int unsigned RAM_BYTES = 256;

   // ***********************************************************
   // Control register fields and reset values.
   // ***********************************************************
   localparam int unsigned B_SET = 7;
   localparam int unsigned B_PIE = 6;
   localparam int unsigned B_AIE = 5;
   localparam int unsigned B_UIE = 4;
   localparam int unsigned B_BIN = 2;
   localparam int unsigned B_H24 = 1;
   localparam int unsigned B_DSE = 0;
   localparam logic [2:0] REG_DIV_RST = 3'h2;
   localparam logic [3:0] REG_RATE_RST = 4'h6;
   localparam logic [7:0] REG_B_RST = 8'h02;
   localparam logic [7:0] REG_D_VAL = 8'h80;
   localparam logic [79:0] TM_RST = 80'h00_01_01_01_00_00_00_00_00_00;

   // ***********************************************************
   // Alarm wildcard, lockable ranges and substitute read data.
   // ***********************************************************
   localparam logic [1:0] ALM_WILD = 2'h3;
   localparam logic [4:0] LOCK0_BLK = 5'h07;
   localparam logic [4:0] LOCK1_BLK = 5'h17;
   localparam logic [7:0] LOCKED_DATA = 8'hff;
   localparam logic [7:0] ISOLATED_DATA = 8'hff;

   typedef enum logic [1:0] {
      UPD_IDLE,
      UPD_WAIT,
      UPD_STEP,
      UPD_CHECK
   } rtcc_upd_e;

endpackage

/* File: rtl/rtcc_alarm.sv */
// Alarm comparator with per-field wildcard.
`timescale 1ns/100ps
`default_nettype none
module rtcc_alarm
   import rtcc_pkg::*;
#(
   parameter int unsigned FIELDS = 3
) (
   input wire logic [8*FIELDS-1:0] now_i,
   input wire logic [8*FIELDS-1:0] alm_i,
   output logic match_o
);
   logic [FIELDS-1:0] hit;

   for (genvar i = 0; i < FIELDS; i++) begin : g_field
      assign hit[i] = (alm_i[8*i+6 +: 2] == ALM_WILD) ||
         (alm_i[8*i +: 8] == now_i[8*i +: 8]);
   end

   assign match_o = &hit;
endmodule
`default_nettype wire

/* File: rtl/rtcc_calendar.sv */
// Next-second calendar step in BCD or binary, 12 or 24 hour.
`timescale 1ns/100ps
`default_nettype none
module rtcc_calendar
   import rtcc_pkg::*;
(
   input wire logic [79:0] tm_i,
   input wire logic bin_i,
   input wire logic h24_i,
   input wire logic dse_i,
   input wire logic back_done_i,
   output logic [79:0] tm_o,
   output logic year_wrap_o,
   output logic fell_back_o
);
   function automatic logic [7:0] to_bin(input logic [7:0] v,
                                         input logic bin);
      return bin ? v : 8'({4'h0, v[7:4]} * 8'h0a + {4'h0, v[3:0]});
   endfunction

   function automatic logic [7:0] to_enc(input logic [7:0] v,
                                         input logic bin);
      logic [7:0] t;
      logic [7:0] u;
      t = v / 8'h0a;
      u = v % 8'h0a;
      return bin ? v : {t[3:0], u[3:0]};
   endfunction

   logic [7:0] s, m, h, w, d, mo, y, dim, h12, h12e, hr_in;

   always_comb begin
      tm_o = tm_i;
      year_wrap_o = 1'b0;
      fell_back_o = 1'b0;
      hr_in = tm_i[IDX_HR*8 +: 8];
      s = to_bin(tm_i[IDX_SEC*8 +: 8], bin_i) + 8'h01;
      m = to_bin(tm_i[IDX_MIN*8 +: 8], bin_i);
      w = to_bin(tm_i[IDX_DOW*8 +: 8], bin_i);
      d = to_bin(tm_i[IDX_DATE*8 +: 8], bin_i);
      mo = to_bin(tm_i[IDX_MON*8 +: 8], bin_i);
      y = to_bin(tm_i[IDX_YEAR*8 +: 8], bin_i);
      h12 = to_bin({1'b0, hr_in[6:0]}, bin_i);
      if (h24_i) begin
         h = to_bin(hr_in, bin_i);
      end else begin
         h = ((h12 == 8'h0c) ? 8'h00 : h12) +
            (hr_in[7] ? 8'h0c : 8'h00);
      end
      if (mo == 8'h02) begin
         dim = (y[1:0] == 2'h0) ? 8'h1d : 8'h1c;
      end else if (mo == 8'h04 || mo == 8'h06 || mo == 8'h09 ||
                   mo == 8'h0b) begin
         dim = 8'h1e;
      end else begin
         dim = 8'h1f;
      end
      if (s == 8'h3c) begin
         s = 8'h00;
         m = m + 8'h01;
      end
      if (m == 8'h3c) begin
         m = 8'h00;
         h = h + 8'h01;
      end
      if (dse_i && w == 8'h01 && h == 8'h02 && m == 8'h00 &&
          s == 8'h00) begin
         if (mo == 8'h04 && d <= 8'h07) begin
            h = 8'h03;
         end else if (mo == 8'h0a && d >= 8'h19 && !back_done_i) begin
            h = 8'h01;
            fell_back_o = 1'b1;
         end
      end
      if (h == 8'h18) begin
         h = 8'h00;
         w = (w == 8'h07) ? 8'h01 : w + 8'h01;
         d = d + 8'h01;
      end
      if (d > dim) begin
         d = 8'h01;
         mo = mo + 8'h01;
      end
      if (mo == 8'h0d) begin
         mo = 8'h01;
         y = y + 8'h01;
      end
      if (y == 8'h64) begin
         y = 8'h00;
         year_wrap_o = 1'b1;
      end
      h12 = h % 8'h0c;
      if (h12 == 8'h00) begin
         h12 = 8'h0c;
      end
      h12e = to_enc(h12, bin_i);
      tm_o[IDX_SEC*8 +: 8] = to_enc(s, bin_i);
      tm_o[IDX_MIN*8 +: 8] = to_enc(m, bin_i);
      tm_o[IDX_HR*8 +: 8] = h24_i ? to_enc(h, bin_i) :
         {(h >= 8'h0c), h12e[6:0]};
      tm_o[IDX_DOW*8 +: 8] = to_enc(w, bin_i);
      tm_o[IDX_DATE*8 +: 8] = to_enc(d, bin_i);
      tm_o[IDX_MON*8 +: 8] = to_enc(mo, bin_i);
      tm_o[IDX_YEAR*8 +: 8] = to_enc(y, bin_i);
   end
endmodule
`default_nettype wire

/* File: rtl/rtcc_core.sv */
// Battery-backed calendar clock with two banks of byte storage.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Two 128-byte banks; 114 general bytes below.
// - Alarm, periodic 30.5 us-500 ms, update-ended interrupts.
// - Count full calendar; 12/24 hour, BCD/binary.
// - 32.768 kHz ticks divided to one second.
// - Locations 0-9 time, 0Ah-0Dh control registers.
// - Alarm byte C0-FF matches any value.
// - Alarm flag needs all fields; irq needs enable.
// - Time writes dropped, reads invalid during update.
// - Every year divisible by four is leap.
// - Alarm compares seconds, minutes, hours only.
// - Update each second unless set-inhibit or bad divider.
// - Update starts 488 us after flag, ends quickly.
// - Time locations isolated from host during update.
// - Interrupt routed internally as line eight only.
// - Two lockable 8-byte ranges: writes dropped, fixed reads.
// - Range lock clears only on hard reset.
// - Year 99 to 00 sets century flag; event in S0.
// - Well reset pin sets lost flag, resets register B, clears alarm and century flags.
// - Optional software-enabled daylight-saving adjustment.
module rtcc_core
   import rtcc_pkg::*;
(
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic osc_tick_i,
   input wire logic rtc_well_reset_pin_n_i,
   input wire logic s0_state_i,
   input wire logic [1:0] lock_set_i,
   input wire logic well_lost_clr_i,
   input wire logic century_clr_i,
   input wire logic [7:0] ram_addr_i,
   input wire logic ram_wr_i,
   input wire logic ram_rd_i,
   input wire logic [7:0] ram_wdata_i,
   output logic [7:0] ram_rdata_o,
   output logic ram_rvalid_o,
   output logic rtc_irq_line_o,
   output logic system_mgmt_interrupt_o,
   output logic century_rollover_flag_o,
   output logic rtc_well_lost_flag_o,
   output logic update_in_progress_flag_o,
   output logic [1:0] lock_o
);
   import rtcc_pkg::*;

   // ***********************************************************
   // State.
   // ***********************************************************
   rtcc_upd_e state_q, state_d;
   logic [DIV_W-1:0] div_cnt_q;
   logic [2:0] div_sel_q;
   logic [3:0] rate_q;
   logic [7:0] reg_b_q;
   logic [79:0] tm_q;
   logic [7:0] ram_q [RAM_BYTES];
   logic update_in_progress_flag_q;
   logic pf_q, alarm_match_flag_q, uf_q;
   logic pf_d, alarm_match_flag_d, uf_d;
   logic century_rollover_flag_q, rtc_well_lost_flag_q;
   logic system_mgmt_interrupt_q, rtc_irq_line_q;
   logic back_done_q;
   logic [1:0] lock_q;
   logic [7:0] rdata_q;
   logic rvalid_q;

   // ***********************************************************
   // Address decode.
   // ***********************************************************
   wire lower_w = ~ram_addr_i[7];
   wire in_time_w = lower_w && ram_addr_i < 8'(TIME_LOCS);
   wire is_a_w = ram_addr_i == IDX_REG_A;
   wire is_b_w = ram_addr_i == IDX_REG_B;
   wire is_c_w = ram_addr_i == IDX_REG_C;
   wire is_d_w = ram_addr_i == IDX_REG_D;
   wire special_w = lower_w && ram_addr_i <= IDX_REG_D;
   wire locked_w = (lock_q[0] && ram_addr_i[7:3] == LOCK0_BLK) ||
      (lock_q[1] && ram_addr_i[7:3] == LOCK1_BLK);
   wire busy_w = state_q == UPD_STEP || state_q == UPD_CHECK;
   wire well_rst_w = ~rtc_well_reset_pin_n_i;
   wire wr_time_w = ram_wr_i && in_time_w && !busy_w;
   wire wr_a_w = ram_wr_i && is_a_w;
   wire wr_b_w = ram_wr_i && is_b_w;
   wire rd_c_w = ram_rd_i && is_c_w;
   wire wr_ram_w = ram_wr_i && !special_w && !locked_w;
   wire [3:0] tsel_w = in_time_w ? ram_addr_i[3:0] : 4'h0;

   // ***********************************************************
   // Divider chain and periodic tap.
   // ***********************************************************
   wire div_run_w = div_sel_q == DIV_NORMAL;
   wire sec_edge_w = osc_tick_i && div_run_w &&
      div_cnt_q == DIV_TOP;
   wire uip_start_w = osc_tick_i && div_run_w &&
      div_cnt_q == UIP_START && !reg_b_q[B_SET];
   wire [DIV_W-1:0] pmask_w = (rate_q == 4'h0) ? '0 :
      DIV_W'((15'h1 << (rate_q - 4'h1)) - 15'h1);
   wire pf_set_w = osc_tick_i && div_run_w && rate_q != 4'h0 &&
      (div_cnt_q & pmask_w) == pmask_w;

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         div_cnt_q <= '0;
      end else if (!div_run_w) begin
         div_cnt_q <= '0;
      end else if (osc_tick_i) begin
         div_cnt_q <= div_cnt_q + 15'h1;
      end
   end

   // ***********************************************************
   // Update sequencer.
   // ***********************************************************
   logic [79:0] tm_next_w;
   logic year_wrap_w, fell_back_w, alarm_hit_w;

   rtcc_calendar u_calendar (
      .tm_i(tm_q),
      .bin_i(reg_b_q[B_BIN]),
      .h24_i(reg_b_q[B_H24]),
      .dse_i(reg_b_q[B_DSE]),
      .back_done_i(back_done_q),
      .tm_o(tm_next_w),
      .year_wrap_o(year_wrap_w),
      .fell_back_o(fell_back_w)
   );

   rtcc_alarm #(
      .FIELDS(3)
   ) u_alarm (
      .now_i({tm_q[IDX_HR*8 +: 8], tm_q[IDX_MIN*8 +: 8],
              tm_q[IDX_SEC*8 +: 8]}),
      .alm_i({tm_q[IDX_HR_ALM*8 +: 8], tm_q[IDX_MIN_ALM*8 +: 8],
              tm_q[IDX_SEC_ALM*8 +: 8]}),
      .match_o(alarm_hit_w)
   );

   always_comb begin
      state_d = state_q;
      case (state_q)
         UPD_IDLE: begin
            if (uip_start_w) begin
               state_d = UPD_WAIT;
            end
         end
         UPD_WAIT: begin
            if (reg_b_q[B_SET] || !div_run_w) begin
               state_d = UPD_IDLE;
            end else if (sec_edge_w) begin
               state_d = UPD_STEP;
            end
         end
         UPD_STEP: begin
            state_d = UPD_CHECK;
         end
         UPD_CHECK: begin
            state_d = UPD_IDLE;
         end
         default: begin
            state_d = UPD_IDLE;
         end
      endcase
   end

   wire upd_step_w = state_q == UPD_STEP;
   wire upd_check_w = state_q == UPD_CHECK;

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_q <= UPD_IDLE;
         update_in_progress_flag_q <= 1'b0;
      end else begin
         state_q <= state_d;
         update_in_progress_flag_q <= state_d != UPD_IDLE;
      end
   end

   // ***********************************************************
   // Time and date locations.
   // ***********************************************************
   for (genvar i = 0; i < TIME_LOCS; i++) begin : g_tm
      always_ff @(posedge clock_i or negedge nrst_i) begin
         if (!nrst_i) begin
            tm_q[i*8 +: 8] <= TM_RST[i*8 +: 8];
         end else if (upd_step_w) begin
            tm_q[i*8 +: 8] <= tm_next_w[i*8 +: 8];
         end else if (wr_time_w && tsel_w == 4'(i)) begin
            tm_q[i*8 +: 8] <= ram_wdata_i;
         end
      end
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         back_done_q <= 1'b0;
      end else if (upd_step_w) begin
         back_done_q <= fell_back_w || (back_done_q &&
            tm_next_w[IDX_DATE*8 +: 8] == tm_q[IDX_DATE*8 +: 8]);
      end
   end

   // ***********************************************************
   // Control registers.
   // ***********************************************************
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         div_sel_q <= REG_DIV_RST;
         rate_q <= REG_RATE_RST;
      end else if (wr_a_w) begin
         div_sel_q <= ram_wdata_i[6:4];
         rate_q <= ram_wdata_i[3:0];
      end
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         reg_b_q <= REG_B_RST;
      end else if (well_rst_w) begin
         reg_b_q <= REG_B_RST;
      end else if (wr_b_w) begin
         reg_b_q <= ram_wdata_i;
      end
   end

   // ***********************************************************
   // Event flags; a set in the register C read cycle wins.
   // ***********************************************************
   assign pf_d = pf_set_w || (pf_q && !rd_c_w);
   assign uf_d = upd_check_w || (uf_q && !rd_c_w);
   assign alarm_match_flag_d = !well_rst_w &&
      ((upd_check_w && alarm_hit_w) ||
       (alarm_match_flag_q && !rd_c_w));
   wire irqf_w = (pf_q && reg_b_q[B_PIE]) ||
      (alarm_match_flag_q && reg_b_q[B_AIE]) ||
      (uf_q && reg_b_q[B_UIE]);
   wire irqf_d_w = (pf_d && reg_b_q[B_PIE]) ||
      (alarm_match_flag_d && reg_b_q[B_AIE]) ||
      (uf_d && reg_b_q[B_UIE]);

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pf_q <= 1'b0;
         uf_q <= 1'b0;
         alarm_match_flag_q <= 1'b0;
         rtc_irq_line_q <= 1'b0;
      end else begin
         pf_q <= pf_d;
         uf_q <= uf_d;
         alarm_match_flag_q <= alarm_match_flag_d;
         rtc_irq_line_q <= irqf_d_w;
      end
   end

   // ***********************************************************
   // Century rollover, well power and range locks.
   // ***********************************************************
   wire century_w = upd_step_w && year_wrap_w;

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         century_rollover_flag_q <= 1'b0;
         system_mgmt_interrupt_q <= 1'b0;
         rtc_well_lost_flag_q <= 1'b0;
      end else begin
         century_rollover_flag_q <= !well_rst_w && (century_w ||
            (century_rollover_flag_q && !century_clr_i));
         system_mgmt_interrupt_q <= century_w && s0_state_i;
         rtc_well_lost_flag_q <= well_rst_w ||
            (rtc_well_lost_flag_q && !well_lost_clr_i);
      end
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         lock_q <= 2'h0;
      end else begin
         lock_q <= lock_q | lock_set_i;
      end
   end

   // ***********************************************************
   // Storage banks and host read path.
   // ***********************************************************
   always_ff @(posedge clock_i) begin
      if (wr_ram_w) begin
         ram_q[ram_addr_i] <= ram_wdata_i;
      end
   end

   wire [7:0] tm_rd_w = busy_w ? ISOLATED_DATA :
      tm_q[tsel_w*8 +: 8];
   wire [7:0] rd_mux_w = locked_w ? LOCKED_DATA :
      in_time_w ? tm_rd_w :
      is_a_w ? {update_in_progress_flag_q, div_sel_q, rate_q} :
      is_b_w ? reg_b_q :
      is_c_w ? {irqf_w, pf_q, alarm_match_flag_q, uf_q, 4'h0} :
      is_d_w ? REG_D_VAL :
      ram_q[ram_addr_i];

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rdata_q <= 8'h00;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= ram_rd_i;
         if (ram_rd_i) begin
            rdata_q <= rd_mux_w;
         end
      end
   end

   // ***********************************************************
   // Outputs.
   // ***********************************************************
   assign ram_rdata_o = rdata_q;
   assign ram_rvalid_o = rvalid_q;
   assign rtc_irq_line_o = rtc_irq_line_q;
   assign system_mgmt_interrupt_o = system_mgmt_interrupt_q;
   assign century_rollover_flag_o = century_rollover_flag_q;
   assign rtc_well_lost_flag_o = rtc_well_lost_flag_q;
   assign update_in_progress_flag_o = update_in_progress_flag_q;
   assign lock_o = lock_q;
endmodule
`default_nettype wire

/* File: sim/rtcc_core_properties.sv */
// Assertions on the ports of the calendar clock core.
`timescale 1ns/100ps
`default_nettype none
module rtcc_core_properties
   import rtcc_pkg::*;
(
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic osc_tick_i,
   input wire logic rtc_well_reset_pin_n_i,
   input wire logic s0_state_i,
   input wire logic [1:0] lock_set_i,
   input wire logic well_lost_clr_i,
   input wire logic century_clr_i,
   input wire logic [7:0] ram_addr_i,
   input wire logic ram_wr_i,
   input wire logic ram_rd_i,
   input wire logic [7:0] ram_wdata_i,
   input wire logic [7:0] ram_rdata_o,
   input wire logic ram_rvalid_o,
   input wire logic rtc_irq_line_o,
   input wire logic system_mgmt_interrupt_o,
   input wire logic century_rollover_flag_o,
   input wire logic rtc_well_lost_flag_o,
   input wire logic update_in_progress_flag_o,
   input wire logic [1:0] lock_o
);
   // ****
   // Oscillator ticks seen while the progress flag is high.
   // ****
   logic [7:0] uip_ticks_q;
   logic locked_hit;
   assign locked_hit = ram_rd_i &&
      ((lock_o[0] && ram_addr_i[7:3] == LOCK0_BLK) ||
       (lock_o[1] && ram_addr_i[7:3] == LOCK1_BLK));
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!nrst_i);
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         uip_ticks_q <= 8'h00;
      end else if (!update_in_progress_flag_o) begin
         uip_ticks_q <= 8'h00;
      end else if (osc_tick_i && uip_ticks_q != 8'hff) begin
         uip_ticks_q <= uip_ticks_q + 8'h01;
      end
   end
   rd_answer_a: assert property (ram_rd_i |=> ram_rvalid_o)
      else $error("read strobe got no answer");
   rvalid_cause_a: assert property (ram_rvalid_o |-> $past(ram_rd_i))
      else $error("read answer without a read");
   lock_sets_a: assert property (|lock_set_i |=>
      (lock_o & $past(lock_set_i)) == $past(lock_set_i))
      else $error("range lock did not set");
   lock_hold_a: assert property (|lock_o |=>
      (lock_o & $past(lock_o)) == $past(lock_o))
      else $error("range lock dropped");
   lock_read_a: assert property (locked_hit |=>
      ram_rdata_o == LOCKED_DATA)
      else $error("locked range returned stored data");
   well_lost_a: assert property (!rtc_well_reset_pin_n_i |=>
      rtc_well_lost_flag_o)
      else $error("well reset did not set lost flag");
   smi_s0_a: assert property (system_mgmt_interrupt_o |->
      $past(s0_state_i))
      else $error("management interrupt outside S0");
   smi_pulse_a: assert property (system_mgmt_interrupt_o |=>
      !system_mgmt_interrupt_o)
      else $error("management interrupt longer than a cycle");
   century_keep_a: assert property (century_rollover_flag_o &&
      !century_clr_i && rtc_well_reset_pin_n_i |=> century_rollover_flag_o)
      else $error("century flag lost");
   uip_span_a: assert property (update_in_progress_flag_o |->
      uip_ticks_q <= 8'd65)
      else $error("update cycle too long");
   cover property ($rose(update_in_progress_flag_o));
   cover property (system_mgmt_interrupt_o);
   cover property (locked_hit);
   cover property ($rose(rtc_irq_line_o));
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
// Self-checking bench for the calendar clock core.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import rtcc_pkg::*;
   logic clock_i = 1'b0;
   logic nrst_i = 1'b0;
   logic tick = 1'b0;
   logic well_n = 1'b1;
   logic s0 = 1'b1;
   logic [1:0] lock_set = 2'h0;
   logic lost_clr = 1'b0;
   logic cent_clr = 1'b0;
   logic [7:0] addr = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata;
   logic rvalid, irq, smi, cent, lost, update_in_progress_flag;
   logic [1:0] lock;
   int errors = 0;
   int n_checks = 0;
   int cyc = 0;
   int n_smi = 0;
   rtcc_core i_rtcc_core (.clock_i(clock_i), .nrst_i(nrst_i),
      .osc_tick_i(tick), .rtc_well_reset_pin_n_i(well_n), .s0_state_i(s0),
      .lock_set_i(lock_set), .well_lost_clr_i(lost_clr),
      .century_clr_i(cent_clr), .ram_addr_i(addr), .ram_wr_i(wr),
      .ram_rd_i(rd), .ram_wdata_i(wdata), .ram_rdata_o(rdata),
      .ram_rvalid_o(rvalid), .rtc_irq_line_o(irq),
      .system_mgmt_interrupt_o(smi), .century_rollover_flag_o(cent),
      .rtc_well_lost_flag_o(lost), .update_in_progress_flag_o(update_in_progress_flag),
      .lock_o(lock));
   // ****
   // Clock, watchdog and shared tasks.
   // ****
   initial begin
      forever #5 clock_i = ~clock_i;
   end
   always @(posedge clock_i) begin
      cyc++;
      if (smi === 1'b1) n_smi++;
      if (cyc == 90000) begin
         errors++;
         end_sim();
      end
   end
   task end_sim();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task wr_b(input logic [7:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock_i);
      wr <= 1'b0;
      @(posedge clock_i);
   endtask
   task rd_b(input logic [7:0] a, output logic [7:0] d);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock_i);
      rd <= 1'b0;
      @(negedge clock_i);
      d = rdata;
      @(posedge clock_i);
   endtask
   task rd_chk(input logic [7:0] a, input logic [7:0] exp, input string nm);
      logic [7:0] d;
      rd_b(a, d);
      chk(nm, d, exp);
   endtask
   task pulse(input logic [1:0] v);
      lock_set <= v;
      @(posedge clock_i);
      lock_set <= 2'h0;
      @(posedge clock_i);
   endtask
   task set_time(input logic [79:0] tm);
      wr_b(IDX_REG_B, 8'h82);
      for (int i = 0; i < 10; i++) wr_b(8'(i), tm[8*i +: 8]);
      wr_b(IDX_REG_B, 8'h22);
   endtask
   task chk_time(input logic [79:0] tm);
      for (int i = 0; i < 10; i++) rd_chk(8'(i), tm[8*i +: 8], "time byte");
   endtask
   // Waits for the progress flag, then runs one access in each of its remaining 17 cycles.
   task run_update(input logic do_wr, output logic seen_ff);
      int k;
      k = 0;
      seen_ff = 1'b0;
      while (update_in_progress_flag !== 1'b1 && k < 40000) begin
         @(negedge clock_i);
         k++;
      end
      chk("uip rise", 8'(update_in_progress_flag), 8'h01);
      @(posedge clock_i);
      addr <= 8'h00;
      wdata <= 8'h59;
      wr <= do_wr;
      rd <= !do_wr;
      repeat (17) begin
         @(negedge clock_i);
         if (rvalid === 1'b1 && rdata === ISOLATED_DATA) seen_ff = 1'b1;
         @(posedge clock_i);
      end
      wr <= 1'b0;
      rd <= 1'b0;
      @(negedge clock_i);
      chk("uip fall", 8'(update_in_progress_flag), 8'h00);
      @(posedge clock_i);
   endtask
   // ****
   // Scenarios.
   // ****
   task t_reset();
      rd_chk(IDX_REG_A, 8'h26, "reg a");
      rd_chk(IDX_REG_B, REG_B_RST, "reg b");
      rd_chk(IDX_REG_C, 8'h00, "reg c");
      rd_chk(IDX_REG_D, REG_D_VAL, "reg d");
      chk_time(TM_RST);
      $display("reset test done");
   endtask
   task t_ram();
      logic [7:0] a [4] = '{8'h0e, 8'h7f, 8'h80, 8'hff};
      foreach (a[i]) wr_b(a[i], ~a[i]);
      foreach (a[i]) rd_chk(a[i], ~a[i], "ram byte");
      wr_b(IDX_REG_D, 8'h00);
      rd_chk(IDX_REG_D, REG_D_VAL, "reg d kept");
      $display("ram test done");
   endtask
   task t_lock();
      wr_b(8'h3a, 8'h5a);
      wr_b(8'hba, 8'ha5);
      pulse(2'h1);
      wr_b(8'h3a, 8'h11);
      rd_chk(8'h3a, LOCKED_DATA, "locked read");
      rd_chk(8'hba, 8'ha5, "open read");
      pulse(2'h2);
      rd_chk(8'hba, LOCKED_DATA, "locked read");
      chk("lock state", 8'(lock), 8'h03);
      nrst_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      nrst_i <= 1'b1;
      @(posedge clock_i);
      chk("lock cleared", 8'(lock), 8'h00);
      rd_chk(8'h3a, 8'h5a, "kept byte");
      $display("lock test done");
   endtask
   task t_well();
      wr_b(IDX_REG_B, 8'h22);
      well_n <= 1'b0;
      @(posedge clock_i);
      well_n <= 1'b1;
      rd_chk(IDX_REG_B, REG_B_RST, "reg b well");
      chk("lost flag", 8'(lost), 8'h01);
      lost_clr <= 1'b1;
      @(posedge clock_i);
      lost_clr <= 1'b0;
      @(posedge clock_i);
      chk("lost clear", 8'(lost), 8'h00);
      $display("well test done");
   endtask
   task t_periodic();
      logic [7:0] d;
      wr_b(IDX_REG_A, 8'h23);
      repeat (8) @(posedge clock_i);
      rd_b(IDX_REG_C, d);
      chk("periodic flag", d & 8'h40, 8'h40);
      chk("irq masked", 8'(irq), 8'h00);
      wr_b(IDX_REG_B, 8'h42);
      repeat (8) @(posedge clock_i);
      chk("irq periodic", 8'(irq), 8'h01);
      wr_b(IDX_REG_A, 8'h20);
      wr_b(IDX_REG_B, REG_B_RST);
      rd_b(IDX_REG_C, d);
      chk("irq cleared", 8'(irq), 8'h00);
      $display("periodic test done");
   endtask
   task t_update1();
      logic seen;
      set_time(80'h99_12_31_05_ff_23_c0_59_00_59);
      run_update(1'b1, seen);
      chk("irq alarm", 8'(irq), 8'h01);
      rd_chk(IDX_REG_C, 8'hb0, "flags");
      rd_chk(IDX_REG_C, 8'h00, "flags read");
      chk_time(80'h00_01_01_06_ff_00_c0_00_00_00);
      chk("century", 8'(cent), 8'h01);
      chk("smi count", 8'(n_smi), 8'h01);
      $display("update one test done");
   endtask
   task t_update2();
      logic seen;
      s0 <= 1'b0;
      set_time(80'h00_02_28_02_ff_23_c0_59_01_59);
      run_update(1'b0, seen);
      chk("isolated", 8'(seen), 8'h01);
      chk("irq none", 8'(irq), 8'h00);
      rd_chk(IDX_REG_C, 8'h10, "flags");
      chk_time(80'h00_02_29_03_ff_00_c0_00_01_00);
      chk("century kept", 8'(cent), 8'h01);
      $display("update two test done");
   endtask
   initial begin
      repeat (2) @(posedge clock_i);
      nrst_i <= 1'b1;
      tick <= 1'b1;
      @(posedge clock_i);
      t_reset();
      t_ram();
      t_lock();
      t_well();
      t_periodic();
      t_update1();
      t_update2();
      end_sim();
   end
endmodule
bind rtcc_core rtcc_core_properties i_rtcc_core_properties (
   .clock_i(clock_i), .nrst_i(nrst_i), .osc_tick_i(osc_tick_i),
   .rtc_well_reset_pin_n_i(rtc_well_reset_pin_n_i),
   .s0_state_i(s0_state_i), .lock_set_i(lock_set_i),
   .well_lost_clr_i(well_lost_clr_i), .century_clr_i(century_clr_i),
   .ram_addr_i(ram_addr_i), .ram_wr_i(ram_wr_i), .ram_rd_i(ram_rd_i),
   .ram_wdata_i(ram_wdata_i), .ram_rdata_o(ram_rdata_o),
   .ram_rvalid_o(ram_rvalid_o), .rtc_irq_line_o(rtc_irq_line_o),
   .system_mgmt_interrupt_o(system_mgmt_interrupt_o),
   .century_rollover_flag_o(century_rollover_flag_o),
   .rtc_well_lost_flag_o(rtc_well_lost_flag_o),
   .update_in_progress_flag_o(update_in_progress_flag_o),
   .lock_o(lock_o));
`default_nettype wire
